/* File: core/imgsig_pkg.sv */
// package: register map, field layout and constants for the image signature inserter
package imgsig_pkg;
  // ==========================================================
  // register offsets (word addresses on the plain port)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LINE_POS = 8'h01;
  localparam logic [7:0] REG_USER_VALUE = 8'h02;
  localparam logic [7:0] REG_ROI_XY = 8'h03;
  localparam logic [7:0] REG_ROI_WH = 8'h04;
  localparam logic [7:0] REG_EXPOSURE = 8'h05;
  localparam logic [7:0] REG_GAIN = 8'h06;
  localparam logic [7:0] REG_SERIAL = 8'h07;
  localparam logic [7:0] REG_TRIG_CNT = 8'h08;
  localparam logic [7:0] REG_FRAME_CNT = 8'h09;
  localparam logic [7:0] REG_SEQ_SEL = 8'h0A;
  localparam logic [7:0] REG_STATUS = 8'h0B;
  localparam logic [7:0] REG_SENSOR_SIZE = 8'h0C;
  localparam logic [7:0] REG_WINDOW = 8'h0D;
  // ==========================================================
  // control register bits
  localparam int CTRL_INSERT_EN = 0;
  localparam int CTRL_SEQ_MODE = 1;
  localparam int CTRL_FIELD_EN_LSB = 8;
  localparam int NUM_FIELDS = 10;
  // ==========================================================
  // field order within the signature line, one 32-bit word each
  localparam logic [3:0] FLD_CYCLE_TIME = 4'h0;
  localparam logic [3:0] FLD_TRIG_CNT = 4'h1;
  localparam logic [3:0] FLD_FRAME_CNT = 4'h2;
  localparam logic [3:0] FLD_ROI_XY = 4'h3;
  localparam logic [3:0] FLD_ROI_WH = 4'h4;
  localparam logic [3:0] FLD_EXPOSURE = 4'h5;
  localparam logic [3:0] FLD_GAIN = 4'h6;
  localparam logic [3:0] FLD_IO_STATE = 4'h7;
  localparam logic [3:0] FLD_SEQ_INDEX = 4'h8;
  localparam logic [3:0] FLD_SERIAL = 4'h9;
  localparam logic [3:0] FLD_USER = 4'hA;
  localparam int BYTES_PER_FIELD = 4;
  // ==========================================================
  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [15:0] RST_SENSOR_W = 16'h0290;
  localparam logic [15:0] RST_SENSOR_H = 16'h01EC;
endpackage

/* File: core/imgsig_sync.sv */
// module: two-flop synchroniser with rising-edge pulse for each of WIDTH pins
`timescale 1ns/1ps
module imgsig_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign level = s2_q;
  assign rise = s2_q & ~s3_q;
endmodule

/* File: core/imgsig_top.sv */
// module: captures per-frame integrity data and inserts it into one image line
// Overview of operation
// - latch bus cycle time at integration start into the timestamp field
// - trigger counter counts only external trigger input rising edges
// - frame counter counts each frame read out of the sensor
// - signature carries region of interest: x offset, y offset, width, height
// - signature carries exposure, gain, serial number and user value
// - sample digital input and output lines at exposure start
// - replace pixels of a configurable line with the enabled fields
// - trigger and frame counters readable directly through registers
// - in sequence mode the sequence index is inserted automatically
// - in sequence mode the selected sequence entry alone takes parameter register writes
// - smaller outputs use a centered sensor window with no binning
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module imgsig_top #(
  parameter int IO_W = 8,
  parameter int SEQ_DEPTH = 16,
  parameter int LINE_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [31:0] cycle_time,
  input wire logic integ_start,
  input wire logic ext_trig_pin,
  input wire logic int_trig,
  input wire logic readout_done,
  input wire logic [IO_W-1:0] io_in_pins,
  input wire logic [IO_W-1:0] io_out_state,
  input wire logic pix_in_valid,
  input wire logic [7:0] pix_in_data,
  input wire logic pix_in_sof,
  input wire logic pix_in_eol,
  output logic pix_out_valid,
  output logic [7:0] pix_out_data,
  output logic pix_out_sof,
  output logic pix_out_eol,
  output logic [15:0] win_x_off,
  output logic [15:0] win_y_off,
  output logic [$clog2(SEQ_DEPTH)-1:0] seq_index
);
  localparam int SEQ_AW = $clog2(SEQ_DEPTH);
  localparam int NF = imgsig_pkg::NUM_FIELDS;

  initial begin
    if (SEQ_DEPTH < 2 || SEQ_DEPTH > 256) $error("SEQ_DEPTH out of range");
    if ((SEQ_DEPTH & (SEQ_DEPTH - 1)) != 0) $error("SEQ_DEPTH not a power of two");
    if (IO_W < 1 || IO_W > 16) $error("IO_W out of range");
    if (LINE_W < 1 || LINE_W > 16) $error("LINE_W out of range");
  end

  // ==========================================================
  // pin synchronisers
  logic [IO_W-1:0] io_in_sync;
  logic ext_trig_level;
  logic ext_trig_rise;

  imgsig_sync #(.WIDTH(IO_W)) u_sync_io (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pin(io_in_pins),
    .level(io_in_sync),
    .rise()
  );

  imgsig_sync #(.WIDTH(1)) u_sync_trig (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pin(ext_trig_pin),
    .level(ext_trig_level),
    .rise(ext_trig_rise)
  );

  // ==========================================================
  // control registers
  logic [31:0] ctrl_q;
  logic [LINE_W-1:0] line_pos_q;
  logic [31:0] user_q;
  logic [31:0] serial_q;
  logic [SEQ_AW-1:0] seq_sel_q;
  logic [31:0] sensor_size_q;
  logic [31:0] window_q;
  logic [31:0] trig_cnt_q;
  logic [31:0] frame_cnt_q;
  logic [31:0] rdata_q;

  // per-entry sequence parameter store
  logic [31:0] seq_roi_xy [SEQ_DEPTH];
  logic [31:0] seq_roi_wh [SEQ_DEPTH];
  logic [31:0] seq_expo [SEQ_DEPTH];
  logic [31:0] seq_gain [SEQ_DEPTH];
  logic [SEQ_AW-1:0] seq_idx_q;

  wire wr_ctrl = reg_wr && reg_addr == imgsig_pkg::REG_CTRL;
  wire wr_line = reg_wr && reg_addr == imgsig_pkg::REG_LINE_POS;
  wire wr_user = reg_wr && reg_addr == imgsig_pkg::REG_USER_VALUE;
  wire wr_xy = reg_wr && reg_addr == imgsig_pkg::REG_ROI_XY;
  wire wr_wh = reg_wr && reg_addr == imgsig_pkg::REG_ROI_WH;
  wire wr_expo = reg_wr && reg_addr == imgsig_pkg::REG_EXPOSURE;
  wire wr_gain = reg_wr && reg_addr == imgsig_pkg::REG_GAIN;
  wire wr_serial = reg_wr && reg_addr == imgsig_pkg::REG_SERIAL;
  wire wr_sel = reg_wr && reg_addr == imgsig_pkg::REG_SEQ_SEL;
  wire wr_size = reg_wr && reg_addr == imgsig_pkg::REG_SENSOR_SIZE;
  wire insert_en = ctrl_q[imgsig_pkg::CTRL_INSERT_EN];
  wire seq_mode = ctrl_q[imgsig_pkg::CTRL_SEQ_MODE];
  wire [NF-1:0] field_en = ctrl_q[imgsig_pkg::CTRL_FIELD_EN_LSB +: NF];
  // outside sequence mode entry zero holds the live parameters
  wire [SEQ_AW-1:0] wr_entry = seq_mode ? seq_sel_q : '0;
  wire [SEQ_AW-1:0] act_entry = seq_mode ? seq_idx_q : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= imgsig_pkg::RST_ZERO;
      line_pos_q <= '0;
      user_q <= imgsig_pkg::RST_ZERO;
      serial_q <= imgsig_pkg::RST_ZERO;
      seq_sel_q <= '0;
      sensor_size_q <= {imgsig_pkg::RST_SENSOR_H, imgsig_pkg::RST_SENSOR_W};
    end else if (ce) begin
      if (wr_ctrl) ctrl_q <= reg_wdata;
      if (wr_line) line_pos_q <= reg_wdata[LINE_W-1:0];
      if (wr_user) user_q <= reg_wdata;
      if (wr_serial) serial_q <= reg_wdata;
      if (wr_sel) seq_sel_q <= reg_wdata[SEQ_AW-1:0];
      if (wr_size) sensor_size_q <= reg_wdata;
    end
  end

  // only the selected entry changes; the others keep their values
  always_ff @(posedge clk) begin
    if (ce && !rst) begin
      if (wr_xy) seq_roi_xy[wr_entry] <= reg_wdata;
      if (wr_wh) seq_roi_wh[wr_entry] <= reg_wdata;
      if (wr_expo) seq_expo[wr_entry] <= reg_wdata;
      if (wr_gain) seq_gain[wr_entry] <= reg_wdata;
    end
  end

  // ==========================================================
  // centered sensor window, no binning
  wire [15:0] act_w = seq_roi_wh[act_entry][15:0];
  wire [15:0] act_h = seq_roi_wh[act_entry][31:16];
  wire [15:0] sens_w = sensor_size_q[15:0];
  wire [15:0] sens_h = sensor_size_q[31:16];
  wire [15:0] cx = (act_w < sens_w) ? 16'((sens_w - act_w) >> 1) : 16'h0000;
  wire [15:0] cy = (act_h < sens_h) ? 16'((sens_h - act_h) >> 1) : 16'h0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      window_q <= imgsig_pkg::RST_ZERO;
    end else if (ce) begin
      window_q <= {cy, cx};
    end
  end
  assign win_x_off = window_q[15:0];
  assign win_y_off = window_q[31:16];

  // ==========================================================
  // counters and exposure-start captures
  logic [31:0] cyc_cap_q;
  logic [IO_W-1:0] io_in_cap_q;
  logic [IO_W-1:0] io_out_cap_q;
  logic [31:0] trig_cap_q;
  logic [31:0] frame_cap_q;
  logic [SEQ_AW-1:0] idx_cap_q;
  logic [31:0] xy_cap_q;
  logic [31:0] wh_cap_q;
  logic [31:0] expo_cap_q;
  logic [31:0] gain_cap_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_cnt_q <= imgsig_pkg::RST_ZERO;
      frame_cnt_q <= imgsig_pkg::RST_ZERO;
      seq_idx_q <= '0;
    end else if (ce) begin
      // int_trig deliberately ignored here
      if (ext_trig_rise) trig_cnt_q <= trig_cnt_q + 32'h0000_0001;
      if (readout_done) begin
        frame_cnt_q <= frame_cnt_q + 32'h0000_0001;
        if (seq_mode) seq_idx_q <= SEQ_AW'(seq_idx_q + 1'b1);
      end
      if (!seq_mode) seq_idx_q <= '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_cap_q <= imgsig_pkg::RST_ZERO;
      io_in_cap_q <= '0;
      io_out_cap_q <= '0;
      idx_cap_q <= '0;
      xy_cap_q <= imgsig_pkg::RST_ZERO;
      wh_cap_q <= imgsig_pkg::RST_ZERO;
      expo_cap_q <= imgsig_pkg::RST_ZERO;
      gain_cap_q <= imgsig_pkg::RST_ZERO;
      trig_cap_q <= imgsig_pkg::RST_ZERO;
    end else if (ce && integ_start) begin
      cyc_cap_q <= cycle_time;
      io_in_cap_q <= io_in_sync;
      io_out_cap_q <= io_out_state;
      idx_cap_q <= act_entry;
      xy_cap_q <= seq_roi_xy[act_entry];
      wh_cap_q <= seq_roi_wh[act_entry];
      expo_cap_q <= seq_expo[act_entry];
      gain_cap_q <= seq_gain[act_entry];
      trig_cap_q <= trig_cnt_q;
    end
  end

  // frame counter snapshot at start of outgoing frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_cap_q <= imgsig_pkg::RST_ZERO;
    end else if (ce && pix_in_valid && pix_in_sof) begin
      frame_cap_q <= frame_cnt_q;
    end
  end
  assign seq_index = seq_idx_q;

  // ==========================================================
  // field table in fixed order
  logic [31:0] fld_val [NF+1];
  logic [NF:0] fld_on;
  assign fld_val[imgsig_pkg::FLD_CYCLE_TIME] = cyc_cap_q;
  assign fld_val[imgsig_pkg::FLD_TRIG_CNT] = trig_cap_q;
  assign fld_val[imgsig_pkg::FLD_FRAME_CNT] = frame_cap_q;
  assign fld_val[imgsig_pkg::FLD_ROI_XY] = xy_cap_q;
  assign fld_val[imgsig_pkg::FLD_ROI_WH] = wh_cap_q;
  assign fld_val[imgsig_pkg::FLD_EXPOSURE] = expo_cap_q;
  assign fld_val[imgsig_pkg::FLD_GAIN] = gain_cap_q;
  assign fld_val[imgsig_pkg::FLD_IO_STATE] = {16'(io_out_cap_q), 16'(io_in_cap_q)};
  assign fld_val[imgsig_pkg::FLD_SEQ_INDEX] = 32'(idx_cap_q);
  assign fld_val[imgsig_pkg::FLD_SERIAL] = serial_q;
  assign fld_val[imgsig_pkg::FLD_USER] = user_q;

  genvar gi;
  generate
    for (gi = 0; gi <= NF; gi++) begin : g_on
      if (gi == imgsig_pkg::FLD_SEQ_INDEX) begin : g_seq
        assign fld_on[gi] = seq_mode;
      end else if (gi > imgsig_pkg::FLD_SEQ_INDEX) begin : g_hi
        assign fld_on[gi] = field_en[gi-1];
      end else begin : g_lo
        assign fld_on[gi] = field_en[gi];
      end
    end
  endgenerate

  // ==========================================================
  // line insertion
  logic [LINE_W-1:0] line_cnt_q;
  logic [15:0] byte_cnt_q;
  logic [7:0] pdata_q;
  logic pvalid_q;
  logic psof_q;
  logic peol_q;

  wire [LINE_W-1:0] cur_line = pix_in_sof ? '0 : line_cnt_q;
  wire in_sig_line = insert_en && cur_line == line_pos_q;
  wire [15:0] byte_idx = pix_in_sof ? 16'h0000 : byte_cnt_q;
  wire [3:0] fld_idx = 4'(byte_idx / imgsig_pkg::BYTES_PER_FIELD);
  wire [1:0] lane = byte_idx[1:0];
  wire fld_ok = fld_idx <= 4'(NF) && byte_idx < 16'((NF + 1) * imgsig_pkg::BYTES_PER_FIELD);
  wire [31:0] fld_word = fld_ok ? fld_val[fld_idx] : imgsig_pkg::RST_ZERO;
  wire fld_use = fld_ok && fld_on[fld_idx];
  wire [7:0] sig_byte = fld_use ? fld_word[8*lane +: 8] : 8'h00;
  wire [7:0] out_byte = in_sig_line ? sig_byte : pix_in_data;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_cnt_q <= '0;
      byte_cnt_q <= 16'h0000;
      pvalid_q <= 1'b0;
      pdata_q <= 8'h00;
      psof_q <= 1'b0;
      peol_q <= 1'b0;
    end else if (ce) begin
      pvalid_q <= pix_in_valid;
      if (pix_in_valid) begin
        pdata_q <= out_byte;
        psof_q <= pix_in_sof;
        peol_q <= pix_in_eol;
        byte_cnt_q <= pix_in_eol ? 16'h0000 : 16'(byte_idx + 16'h0001);
        line_cnt_q <= pix_in_eol ? LINE_W'(cur_line + 1'b1) : cur_line;
      end
    end
  end
  assign pix_out_valid = pvalid_q;
  assign pix_out_data = pdata_q;
  assign pix_out_sof = psof_q;
  assign pix_out_eol = peol_q;

  // ==========================================================
  // read port
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = imgsig_pkg::RST_ZERO;
    unique case (reg_addr)
      imgsig_pkg::REG_CTRL: rd_mux = ctrl_q;
      imgsig_pkg::REG_LINE_POS: rd_mux = 32'(line_pos_q);
      imgsig_pkg::REG_USER_VALUE: rd_mux = user_q;
      imgsig_pkg::REG_ROI_XY: rd_mux = seq_roi_xy[wr_entry];
      imgsig_pkg::REG_ROI_WH: rd_mux = seq_roi_wh[wr_entry];
      imgsig_pkg::REG_EXPOSURE: rd_mux = seq_expo[wr_entry];
      imgsig_pkg::REG_GAIN: rd_mux = seq_gain[wr_entry];
      imgsig_pkg::REG_SERIAL: rd_mux = serial_q;
      imgsig_pkg::REG_TRIG_CNT: rd_mux = trig_cnt_q;
      imgsig_pkg::REG_FRAME_CNT: rd_mux = frame_cnt_q;
      imgsig_pkg::REG_SEQ_SEL: rd_mux = 32'(seq_sel_q);
      imgsig_pkg::REG_STATUS: rd_mux = {16'h0000, 15'(seq_idx_q), ext_trig_level};
      imgsig_pkg::REG_SENSOR_SIZE: rd_mux = sensor_size_q;
      imgsig_pkg::REG_WINDOW: rd_mux = window_q;
      default: rd_mux = imgsig_pkg::RST_ZERO;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= imgsig_pkg::RST_ZERO;
    end else if (ce) begin
      rdata_q <= reg_rd ? rd_mux : imgsig_pkg::RST_ZERO;
    end
  end
  assign reg_rdata = rdata_q;

  wire unused_ok = int_trig;
endmodule

/* File: test/imgsig_assertions.sv */
// checker: port-level assertions for the signature inserter
`timescale 1ns/1ps
module imgsig_assertions #(
  parameter int SEQ_DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic readout_done,
  input wire logic pix_in_valid,
  input wire logic [7:0] pix_in_data,
  input wire logic pix_in_sof,
  input wire logic pix_in_eol,
  input wire logic pix_out_valid,
  input wire logic [7:0] pix_out_data,
  input wire logic pix_out_sof,
  input wire logic pix_out_eol,
  input wire logic [$clog2(SEQ_DEPTH)-1:0] seq_index
);
  // ====
  // shadow of control, line position and stream position
  logic [31:0] ctrl_q;
  logic [15:0] lpos_q, line_q, col_q;
  wire [15:0] line_now = pix_in_sof ? 16'h0000 : line_q;
  wire [15:0] col_now = pix_in_sof ? 16'h0000 : col_q;
  wire [3:0] fld = col_now[5:2];
  wire fld_on = (col_now < 16'd44) && ((fld == 4'h8) ? ctrl_q[1] :
    ctrl_q[(fld < 4'h8) ? fld + 8 : fld + 7]);
  wire sig_line = ctrl_q[0] && (line_now == lpos_q);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= 32'h0000_0000;
      lpos_q <= 16'h0000;
      line_q <= 16'h0000;
      col_q <= 16'h0000;
    end else if (ce) begin
      if (reg_wr && reg_addr == imgsig_pkg::REG_CTRL) ctrl_q <= reg_wdata;
      if (reg_wr && reg_addr == imgsig_pkg::REG_LINE_POS) lpos_q <= reg_wdata[15:0];
      if (pix_in_valid) begin
        line_q <= line_now + {15'h0, pix_in_eol};
        col_q <= pix_in_eol ? 16'h0000 : col_now + 16'h0001;
      end
    end
  end
  // ====
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_beat;
    ce && pix_in_valid;
  endsequence
  sequence s_plain;
    ce && pix_in_valid && !sig_line;
  endsequence
  sequence s_blank;
    ce && pix_in_valid && sig_line && !fld_on;
  endsequence
  property p_rdata_idle;
    ce && !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  property p_unmapped;
    ce && reg_rd && reg_addr > imgsig_pkg::REG_WINDOW |=> reg_rdata == 32'h0000_0000;
  endproperty
  property p_out_beat;
    s_beat |=> pix_out_valid && pix_out_sof == $past(pix_in_sof)
      && pix_out_eol == $past(pix_in_eol);
  endproperty
  property p_out_idle;
    ce && !pix_in_valid |=> !pix_out_valid;
  endproperty
  property p_passthru;
    s_plain |=> pix_out_data == $past(pix_in_data);
  endproperty
  property p_sig_zero;
    s_blank |=> pix_out_data == 8'h00;
  endproperty
  property p_seq_step;
    ce && readout_done && ctrl_q[1] |=> seq_index == $past(seq_index) + 1'b1;
  endproperty
  property p_seq_hold;
    ce && !reg_wr && !(readout_done && ctrl_q[1]) |=> $stable(seq_index);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_out_beat: assert property (p_out_beat) else $error("output beat wrong");
  a_out_idle: assert property (p_out_idle) else $error("spurious output beat");
  a_passthru: assert property (p_passthru) else $error("pixel altered");
  a_sig_zero: assert property (p_sig_zero) else $error("blank field not zero");
  a_seq_step: assert property (p_seq_step) else $error("step did not advance");
  a_seq_hold: assert property (p_seq_hold) else $error("step moved");
endmodule
bind imgsig_top imgsig_assertions #(.SEQ_DEPTH(SEQ_DEPTH)) i_imgsig_assertions (
  .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .readout_done(readout_done),
  .pix_in_valid(pix_in_valid), .pix_in_data(pix_in_data), .pix_in_sof(pix_in_sof),
  .pix_in_eol(pix_in_eol), .pix_out_valid(pix_out_valid), .pix_out_data(pix_out_data),
  .pix_out_sof(pix_out_sof), .pix_out_eol(pix_out_eol), .seq_index(seq_index));

/* File: test/imgsig_host_model.sv */
// partner: host side collecting the delivered image lines
`timescale 1ns/1ps
module imgsig_host_model (
  input wire logic clk,
  input wire logic pix_out_valid,
  input wire logic [7:0] pix_out_data,
  input wire logic pix_out_sof,
  input wire logic pix_out_eol,
  output logic [7:0] img [0:2][0:47]
);
  int line = 0;
  int col = 0;
  // ====
  // store each byte at its line and column
  always @(posedge clk) begin
    if (pix_out_valid) begin
      if (pix_out_sof) begin
        line = 0;
        col = 0;
      end
      if (line < 3 && col < 48) img[line][col] <= pix_out_data;
      col = pix_out_eol ? 0 : col + 1;
      if (pix_out_eol) line = line + 1;
    end
  end
endmodule

/* File: test/imgsig_top_tb.sv */
// testbench: registers, triggers and frames against the signature line
`timescale 1ns/1ps
module imgsig_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] cycle_time = 32'h0000_0000;
  logic reg_wr = 1'b0, reg_rd = 1'b0, integ_start = 1'b0, ext_trig_pin = 1'b0;
  logic int_trig = 1'b0, readout_done = 1'b0;
  logic pix_in_valid = 1'b0, pix_in_sof = 1'b0, pix_in_eol = 1'b0;
  logic [7:0] pix_in_data = 8'h00, io_in_pins = 8'h3C, io_out_state = 8'hA5;
  logic [31:0] reg_rdata, rv;
  logic pix_out_valid, pix_out_sof, pix_out_eol;
  logic [7:0] pix_out_data;
  logic [15:0] win_x_off, win_y_off;
  logic [3:0] seq_index;
  logic [7:0] img [0:2][0:47];
  int fail_count = 0;
  int num_checks = 0;
  always #50 clk = ~clk;
  imgsig_top i_imgsig_top (
    .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cycle_time(cycle_time),
    .integ_start(integ_start), .ext_trig_pin(ext_trig_pin), .int_trig(int_trig),
    .readout_done(readout_done), .io_in_pins(io_in_pins), .io_out_state(io_out_state),
    .pix_in_valid(pix_in_valid), .pix_in_data(pix_in_data), .pix_in_sof(pix_in_sof),
    .pix_in_eol(pix_in_eol), .pix_out_valid(pix_out_valid), .pix_out_data(pix_out_data),
    .pix_out_sof(pix_out_sof), .pix_out_eol(pix_out_eol), .win_x_off(win_x_off),
    .win_y_off(win_y_off), .seq_index(seq_index));
  imgsig_host_model i_imgsig_host_model (
    .clk(clk), .pix_out_valid(pix_out_valid), .pix_out_data(pix_out_data),
    .pix_out_sof(pix_out_sof), .pix_out_eol(pix_out_eol), .img(img));
  // ====
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic integ(input logic [31:0] ct);
    @(posedge clk);
    cycle_time <= ct;
    integ_start <= 1'b1;
    @(posedge clk);
    integ_start <= 1'b0;
  endtask
  task automatic pulse_ro();
    @(posedge clk);
    readout_done <= 1'b1;
    @(posedge clk);
    readout_done <= 1'b0;
  endtask
  task automatic send_frame();
    for (int l = 0; l < 3; l++) begin
      for (int n = 0; n < 48; n++) begin
        @(posedge clk);
        pix_in_valid <= 1'b1;
        pix_in_data <= 8'(l * 48 + n + 1);
        pix_in_sof <= (l == 0 && n == 0);
        pix_in_eol <= (n == 47);
      end
    end
    @(posedge clk);
    pix_in_valid <= 1'b0;
    pix_in_sof <= 1'b0;
    pix_in_eol <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [31:0] sig_word(input int k);
    return {img[1][4*k+3], img[1][4*k+2], img[1][4*k+1], img[1][4*k]};
  endfunction
  // ====
  // scenarios
  task automatic t_regs();
    rd(imgsig_pkg::REG_SENSOR_SIZE, rv);
    chk(rv, {imgsig_pkg::RST_SENSOR_H, imgsig_pkg::RST_SENSOR_W});
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, rv);
    chk(rv, 32'h0000_0000);
    wr(imgsig_pkg::REG_USER_VALUE, 32'h1234_5678);
    rd(imgsig_pkg::REG_USER_VALUE, rv);
    chk(rv, 32'h1234_5678);
    $display("test regs done");
  endtask
  task automatic t_counters();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      int_trig <= 1'b1;
      ext_trig_pin <= 1'b1;
      @(posedge clk);
      int_trig <= 1'b0;
      repeat (4) @(posedge clk);
      ext_trig_pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
    rd(imgsig_pkg::REG_TRIG_CNT, rv);
    chk(rv, 32'h0000_0003);
    wr(imgsig_pkg::REG_TRIG_CNT, 32'h0000_00FF);
    rd(imgsig_pkg::REG_TRIG_CNT, rv);
    chk(rv, 32'h0000_0003);
    @(posedge clk);
    ce <= 1'b0;
    pulse_ro();
    ce <= 1'b1;
    pulse_ro();
    pulse_ro();
    rd(imgsig_pkg::REG_FRAME_CNT, rv);
    chk(rv, 32'h0000_0002);
    $display("test counters done");
  endtask
  task automatic t_signature();
    logic [31:0] exp_w [0:10];
    exp_w = '{32'hCAFE_0001, 32'h0000_0003, 32'h0000_0002, 32'h0010_0020, 32'h0080_0100,
      32'h0000_0ABC, 32'h0000_0011, 32'h00A5_003C, 32'h0000_0000, 32'h0000_4321,
      32'h1234_5678};
    wr(imgsig_pkg::REG_CTRL, 32'h0003_FF01);
    wr(imgsig_pkg::REG_LINE_POS, 32'h0000_0001);
    wr(imgsig_pkg::REG_ROI_XY, 32'h0010_0020);
    wr(imgsig_pkg::REG_ROI_WH, 32'h0080_0100);
    wr(imgsig_pkg::REG_EXPOSURE, 32'h0000_0ABC);
    wr(imgsig_pkg::REG_GAIN, 32'h0000_0011);
    wr(imgsig_pkg::REG_SERIAL, 32'h0000_4321);
    integ(32'hCAFE_0001);
    rd(imgsig_pkg::REG_WINDOW, rv);
    chk(rv, 32'h00B6_00C8);
    chk({win_y_off, win_x_off}, 32'h00B6_00C8);
    send_frame();
    for (int k = 0; k < 11; k++) chk(sig_word(k), exp_w[k]);
    chk(32'(img[1][44]), 32'h0000_0000);
    chk(32'(img[0][5]), 32'h0000_0006);
    chk(32'(img[2][47]), 32'h0000_0090);
    $display("test signature done");
  endtask
  task automatic t_seq();
    wr(imgsig_pkg::REG_CTRL, 32'h0000_2003);
    wr(imgsig_pkg::REG_SEQ_SEL, 32'h0000_0001);
    wr(imgsig_pkg::REG_EXPOSURE, 32'h0000_0DEF);
    wr(imgsig_pkg::REG_SEQ_SEL, 32'h0000_0000);
    integ(32'h0000_0100);
    send_frame();
    chk(sig_word(5), 32'h0000_0ABC);
    chk(sig_word(8), 32'h0000_0000);
    pulse_ro();
    repeat (2) @(posedge clk);
    chk(32'(seq_index), 32'h0000_0001);
    rd(imgsig_pkg::REG_STATUS, rv);
    chk(rv, 32'h0000_0002);
    integ(32'h0000_0200);
    send_frame();
    chk(sig_word(5), 32'h0000_0DEF);
    chk(sig_word(8), 32'h0000_0001);
    chk(sig_word(0), 32'h0000_0000);
    $display("test sequence done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_counters();
    t_signature();
    t_seq();
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule
